// >>> rtl/bsh_consts.svh
// constants for the buck soft-start and hiccup sequencer
`ifndef BSH_CONSTS_SVH
`define BSH_CONSTS_SVH
`define BSH_CLK_PERIOD_NS 40
`define BSH_SS_TIME_US 3000
`define BSH_TON_MIN_NS 50
`define BSH_SS_CLAMP_MV 150
`define BSH_OCP_LIMIT 10'h200
`define BSH_OCP_LAST 10'h1ff
`define BSH_OFF_LIMIT 15'h4000
`define BSH_OFF_LAST 15'h3fff
`define BSH_CLEAN_LAST 3'h3
`define BSH_EVT_LIMIT 5'h10
`define BSH_TON_MIN_CYC ((`BSH_TON_MIN_NS + `BSH_CLK_PERIOD_NS - 1) / `BSH_CLK_PERIOD_NS)
`define BSH_SS_CYC ((`BSH_SS_TIME_US * 1000) / `BSH_CLK_PERIOD_NS)
`define BSH_SYNC_W 8
`endif

// >>> rtl/bsh_pkg.sv
// types for the buck soft-start and hiccup sequencer
`default_nettype none
package bsh_pkg;
    typedef enum logic [1:0] {BSH_OFF, BSH_SOFT, BSH_RUN, BSH_HICCUP} bsh_state_type;
    typedef enum logic [1:0] {BSH_VOUT_3V3, BSH_VOUT_5V, BSH_VOUT_12V, BSH_VOUT_EXT} bsh_setpoint_type;
endpackage : bsh_pkg
`default_nettype wire

// >>> rtl/bsh_ctrl.sv
// buck soft-start, config latch, pulse skip, current limit and hiccup control
// Functional notes
// - soft start begins only while the bias rail is above 3.3 V and enable is above 1 V.
// - an internal timer of about 3 ms ramps the regulation target up to its final value.
// - at power-up the feedback pull-up code selects 3.3 V, 5 V, 12 V or the external divider.
// - the setpoint stays latched until the bias rail drops below UVLO and rises above 3.4 V again.
// - a 10 k pull-up on the compensation node selects internal compensation, latched until bias drops.
// - when the needed on-time is below the 50 ns minimum, pulses are skipped to keep regulating.
// - a current-sense peak above 60 mV ends the present high-side pulse at once.
// - the soft-start ramp is clamped 150 mV above feedback only after sixteen overcurrent events.
// - an overload allows 512 switching cycles of current limiting before hiccup.
// - four consecutive clean switching cycles clear the overload cycle counter.
// - on overload expiry the ramp is pulled low, both drives are off and a 16384-cycle off timer runs.
// - when the off timer reaches 16384 the ramp is released and a normal soft start follows.
// - hiccup protection is inactive during soft start until feedback exceeds 0.4 V.
`timescale 1ns/100ps
`default_nettype none
`include "bsh_consts.svh"
module bsh_ctrl #(
    parameter int RAMP_W = 8,
    parameter int SS_CYCLES = `BSH_SS_CYC
) (
    input wire logic i_ref_clk,
    input wire logic i_rst,
    input wire logic i_analog_bias_rail_ok,
    input wire logic i_enable_ok,
    input wire logic [1:0] i_feedback_sense_code,
    input wire logic i_compensation_node_det,
    input wire logic i_osc_cycle,
    input wire logic i_pwm_end,
    input wire logic i_current_sense_pos_trip,
    input wire logic i_feedback_sense_above_0v4,
    output logic o_high_side_gate_drive,
    output logic o_low_side_gate_drive,
    output logic [RAMP_W-1:0] o_soft_start_ramp,
    output logic o_ss_clamp_en,
    output logic o_pulse_skip,
    output logic o_hiccup,
    output bsh_pkg::bsh_setpoint_type o_setpoint_sel,
    output logic o_comp_internal
);
    localparam int STEP_CYC = (SS_CYCLES >> RAMP_W) > 0 ? (SS_CYCLES >> RAMP_W) : 1;
    localparam int STEP_W = $clog2(STEP_CYC + 1);
    localparam logic [STEP_W-1:0] STEP_LAST = STEP_W'(STEP_CYC - 1);
    localparam logic [2:0] TON_LAST = 3'(`BSH_TON_MIN_CYC - 1);

    // every pin input is a comparator or oscillator output: two flops before use
    logic [`BSH_SYNC_W-1:0] sync_in;
    logic [`BSH_SYNC_W-1:0] meta_reg;
    logic [`BSH_SYNC_W-1:0] sync_reg;
    logic osc_prev_reg;
    assign sync_in = {i_analog_bias_rail_ok, i_enable_ok, i_feedback_sense_code, i_compensation_node_det,
                      i_osc_cycle, i_pwm_end, i_current_sense_pos_trip};
    genvar g;
    generate
        for (g = 0; g < `BSH_SYNC_W; g++)
        begin : g_sync
            always_ff @(posedge i_ref_clk or posedge i_rst)
            begin
                if (i_rst)
                begin
                    meta_reg[g] <= 1'b0;
                    sync_reg[g] <= 1'b0;
                end
                else
                begin
                    meta_reg[g] <= sync_in[g];
                    sync_reg[g] <= meta_reg[g];
                end
            end
        end
    endgenerate

    logic fb04_meta_reg;
    logic fb04_reg;
    logic bias_s;
    logic en_s;
    logic [1:0] fbcode_s;
    logic compdet_s;
    logic osc_s;
    logic pwm_end_s;
    logic cl_s;
    logic tick;
    assign {bias_s, en_s, fbcode_s, compdet_s, osc_s, pwm_end_s, cl_s} = sync_reg;
    assign tick = osc_s & ~osc_prev_reg;

    function automatic bsh_pkg::bsh_setpoint_type decode_fb(input logic [1:0] code);
        case (code)
            2'h0: decode_fb = bsh_pkg::BSH_VOUT_3V3;
            2'h1: decode_fb = bsh_pkg::BSH_VOUT_5V;
            2'h2: decode_fb = bsh_pkg::BSH_VOUT_12V;
            default: decode_fb = bsh_pkg::BSH_VOUT_EXT;
        endcase
    endfunction : decode_fb

    bsh_pkg::bsh_state_type state_reg, state_next;
    logic cfg_reg, cfg_next;
    bsh_pkg::bsh_setpoint_type setpt_reg, setpt_next;
    logic comp_reg, comp_next;
    logic [RAMP_W-1:0] ramp_reg, ramp_next;
    logic [STEP_W-1:0] step_reg, step_next;
    logic ho_reg, ho_next;
    logic lo_reg, lo_next;
    logic [2:0] ton_reg, ton_next;
    logic skip_reg, skip_next;
    logic cyc_cl_reg, cyc_cl_next;
    logic [9:0] ocp_reg, ocp_next;
    logic [2:0] clean_reg, clean_next;
    logic [4:0] evt_reg, evt_next;
    logic [14:0] off_reg, off_next;
    logic clamp_reg, clamp_next;
    logic armed;
    logic cyc_cl;
    logic expire;

    always_comb
    begin
        state_next = state_reg;
        cfg_next = cfg_reg;
        setpt_next = setpt_reg;
        comp_next = comp_reg;
        ramp_next = ramp_reg;
        step_next = step_reg;
        ho_next = ho_reg;
        ton_next = ton_reg;
        skip_next = skip_reg;
        cyc_cl_next = cyc_cl_reg | cl_s;
        ocp_next = ocp_reg;
        clean_next = clean_reg;
        evt_next = evt_reg;
        off_next = off_reg;
        clamp_next = clamp_reg;
        cyc_cl = cyc_cl_reg | cl_s;
        armed = (state_reg == bsh_pkg::BSH_RUN) |
                ((state_reg == bsh_pkg::BSH_SOFT) & fb04_reg);
        expire = tick & cyc_cl & armed & (ocp_reg == `BSH_OCP_LAST);
        // config is caught once per bias power-up; software cannot reopen it
        if (!bias_s)
        begin
            cfg_next = 1'b0;
        end
        else if (!cfg_reg)
        begin
            cfg_next = 1'b1;
            setpt_next = decode_fb(fbcode_s);
            comp_next = compdet_s;
        end
        if (tick)
        begin
            cyc_cl_next = 1'b0;
        end
        // cycle accounting on each oscillator edge while hiccup protection is armed
        if (tick && armed)
        begin
            if (cyc_cl)
            begin
                clean_next = 3'h0;
                ocp_next = ocp_reg + 10'h001;
                if (evt_reg != `BSH_EVT_LIMIT)
                begin
                    evt_next = evt_reg + 5'h01;
                end
            end
            else if (clean_reg == `BSH_CLEAN_LAST)
            begin
                clean_next = 3'h0;
                ocp_next = 10'h000;
            end
            else
            begin
                clean_next = clean_reg + 3'h1;
            end
        end
        // 150 mV clamp is analog; this only enables it
        clamp_next = cyc_cl & (evt_reg == `BSH_EVT_LIMIT);
        // high-side pulse: starts on the cycle edge, ends on current limit, on pwm end after the minimum on-time, or at the next cycle edge
        if (ho_reg)
        begin
            if (ton_reg != TON_LAST)
            begin
                ton_next = ton_reg + 3'h1;
            end
            if (cl_s)
            begin
                ho_next = 1'b0;
            end
            else if (pwm_end_s && ton_reg == TON_LAST)
            begin
                ho_next = 1'b0;
            end
            else if (pwm_end_s)
            begin
                skip_next = 1'b1;
            end
        end
        if (tick)
        begin
            ho_next = 1'b0;
            ton_next = 3'h0;
            // demand shorter than the minimum on-time: drop this pulse instead
            if (skip_reg)
            begin
                skip_next = 1'b0;
            end
            else if ((state_reg == bsh_pkg::BSH_SOFT || state_reg == bsh_pkg::BSH_RUN) && !cl_s && !expire)
            begin
                ho_next = 1'b1;
            end
        end
        case (state_reg)
            bsh_pkg::BSH_OFF:
            begin
                ramp_next = '0;
                step_next = '0;
                if (bias_s && en_s && cfg_reg)
                begin
                    state_next = bsh_pkg::BSH_SOFT;
                end
            end
            bsh_pkg::BSH_SOFT:
            begin
                if (step_reg == STEP_LAST)
                begin
                    step_next = '0;
                    ramp_next = ramp_reg + RAMP_W'(1);
                    if (ramp_reg == {{(RAMP_W-1){1'b1}}, 1'b0})
                    begin
                        state_next = bsh_pkg::BSH_RUN;
                    end
                end
                else
                begin
                    step_next = step_reg + STEP_W'(1);
                end
            end
            bsh_pkg::BSH_RUN:
            begin
                ramp_next = '1;
            end
            bsh_pkg::BSH_HICCUP:
            begin
                ramp_next = '0;
                ho_next = 1'b0;
                if (tick)
                begin
                    off_next = off_reg + 15'h0001;
                    if (off_reg == `BSH_OFF_LAST)
                    begin
                        state_next = bsh_pkg::BSH_SOFT;
                        off_next = 15'h0000;
                        ocp_next = 10'h000;
                        evt_next = 5'h00;
                        clean_next = 3'h0;
                        step_next = '0;
                    end
                end
            end
            default:
            begin
                state_next = bsh_pkg::BSH_OFF;
            end
        endcase
        if (expire)
        begin
            state_next = bsh_pkg::BSH_HICCUP;
            ramp_next = '0;
            ho_next = 1'b0;
            off_next = 15'h0000;
        end
        if (!bias_s || !en_s)
        begin
            state_next = bsh_pkg::BSH_OFF;
            ho_next = 1'b0;
            ramp_next = '0;
            ocp_next = 10'h000;
            clean_next = 3'h0;
            evt_next = 5'h00;
            off_next = 15'h0000;
            skip_next = 1'b0;
            clamp_next = 1'b0;
        end
        // one dead cycle after the high side falls before the low side turns on
        lo_next = (state_next == bsh_pkg::BSH_SOFT || state_next == bsh_pkg::BSH_RUN) & ~ho_next & ~ho_reg;
    end

    always_ff @(posedge i_ref_clk or posedge i_rst)
    begin
        if (i_rst)
        begin
            osc_prev_reg <= 1'b0;
            fb04_meta_reg <= 1'b0;
            fb04_reg <= 1'b0;
            state_reg <= bsh_pkg::BSH_OFF;
            cfg_reg <= 1'b0;
            setpt_reg <= bsh_pkg::BSH_VOUT_EXT;
            comp_reg <= 1'b0;
            ramp_reg <= '0;
            step_reg <= '0;
            ho_reg <= 1'b0;
            lo_reg <= 1'b0;
            ton_reg <= 3'h0;
            skip_reg <= 1'b0;
            cyc_cl_reg <= 1'b0;
            ocp_reg <= 10'h000;
            clean_reg <= 3'h0;
            evt_reg <= 5'h00;
            off_reg <= 15'h0000;
            clamp_reg <= 1'b0;
        end
        else
        begin
            osc_prev_reg <= osc_s;
            fb04_meta_reg <= i_feedback_sense_above_0v4;
            fb04_reg <= fb04_meta_reg;
            state_reg <= state_next;
            cfg_reg <= cfg_next;
            setpt_reg <= setpt_next;
            comp_reg <= comp_next;
            ramp_reg <= ramp_next;
            step_reg <= step_next;
            ho_reg <= ho_next;
            lo_reg <= lo_next;
            ton_reg <= ton_next;
            skip_reg <= skip_next;
            cyc_cl_reg <= cyc_cl_next;
            ocp_reg <= ocp_next;
            clean_reg <= clean_next;
            evt_reg <= evt_next;
            off_reg <= off_next;
            clamp_reg <= clamp_next;
        end
    end

    assign o_high_side_gate_drive = ho_reg;
    assign o_low_side_gate_drive = lo_reg;
    assign o_soft_start_ramp = ramp_reg;
    assign o_ss_clamp_en = clamp_reg;
    assign o_pulse_skip = skip_reg;
    assign o_hiccup = (state_reg == bsh_pkg::BSH_HICCUP);
    assign o_setpoint_sel = setpt_reg;
    assign o_comp_internal = comp_reg;

    default clocking cb @(posedge i_ref_clk); endclocking
    default disable iff (i_rst);

    property p_start_gate;
        state_reg == bsh_pkg::BSH_OFF && !(bias_s && en_s) |=> state_reg == bsh_pkg::BSH_OFF;
    endproperty
    a_start_gate: assert property (p_start_gate) else $error("soft start without bias and enable");
    property p_ramp_up;
        state_reg == bsh_pkg::BSH_SOFT && state_next == bsh_pkg::BSH_SOFT |=> ramp_reg >= $past(ramp_reg);
    endproperty
    a_ramp_up: assert property (p_ramp_up) else $error("soft-start ramp went down");
    property p_cfg_hold;
        cfg_reg && bias_s |=> $stable(setpt_reg) && $stable(comp_reg);
    endproperty
    a_cfg_hold: assert property (p_cfg_hold) else $error("latched config changed");
    property p_skip;
        skip_reg && tick |=> !ho_reg;
    endproperty
    a_skip: assert property (p_skip) else $error("pulse not skipped");
    property p_cl_cut;
        ho_reg && cl_s |=> !ho_reg;
    endproperty
    a_cl_cut: assert property (p_cl_cut) else $error("high side not ended on current limit");
    property p_clamp16;
        clamp_reg |-> evt_reg == `BSH_EVT_LIMIT;
    endproperty
    a_clamp16: assert property (p_clamp16) else $error("clamp before sixteen events");
    sequence s_expire;
        expire && bias_s && en_s;
    endsequence
    sequence s_shut;
        o_hiccup && !ho_reg && !lo_reg && ramp_reg == '0 && off_reg == 15'h0000;
    endsequence
    property p_hiccup;
        s_expire |=> s_shut;
    endproperty
    a_hiccup: assert property (p_hiccup) else $error("hiccup entry wrong");
    property p_clean;
        tick && armed && !cyc_cl && clean_reg == `BSH_CLEAN_LAST && bias_s && en_s |=> ocp_reg == 10'h000;
    endproperty
    a_clean: assert property (p_clean) else $error("overload count not cleared");
    property p_restart;
        o_hiccup && tick && off_reg == `BSH_OFF_LAST && bias_s && en_s
            |=> state_reg == bsh_pkg::BSH_SOFT && ocp_reg == 10'h000 && evt_reg == 5'h00;
    endproperty
    a_restart: assert property (p_restart) else $error("hiccup restart wrong");
    property p_unarmed;
        state_reg == bsh_pkg::BSH_SOFT && !fb04_reg && bias_s && en_s |=> $stable(ocp_reg);
    endproperty
    a_unarmed: assert property (p_unarmed) else $error("hiccup counted before 0.4 V");
    property p_uvlo;
        !bias_s |=> ocp_reg == 10'h000 && off_reg == 15'h0000 && !ho_reg;
    endproperty
    a_uvlo: assert property (p_uvlo) else $error("counters not cleared under UVLO");
endmodule : bsh_ctrl
`default_nettype wire

// >>> dv/bsh_stage_model.sv
// behavioural power stage, sense network and oscillator around the sequencer
`timescale 1ns/100ps
`default_nettype none
module bsh_stage_model (
    input wire logic i_ref_clk,
    input wire logic i_high_side_gate_drive,
    input wire logic [7:0] i_soft_start_ramp,
    input wire logic i_overload,
    input wire logic i_fb_good,
    input wire logic [3:0] i_pwm_len,
    output logic o_osc_cycle,
    output logic o_pwm_end,
    output logic o_current_sense_pos_trip,
    output logic o_feedback_sense_above_0v4
);
    // oscillator at a quarter of the reference keeps the long off time short
    logic [1:0] osc_reg = 2'h0;
    logic [3:0] on_reg = 4'h0;
    always @(posedge i_ref_clk)
    begin
        osc_reg <= osc_reg + 2'h1;
        // the comparator restarts with every switching cycle, so a long demand never ends a pulse early
        on_reg <= (i_high_side_gate_drive && osc_reg != 2'h1) ? on_reg + 4'h1 : 4'h0;
        // zero length: the comparator already says stop, as with a tiny duty ratio
        o_pwm_end <= (i_pwm_len == 4'h0) || (i_high_side_gate_drive && on_reg >= i_pwm_len);
        o_current_sense_pos_trip <= i_overload && i_high_side_gate_drive;
        // feedback collapses while the ramp is pulled down
        o_feedback_sense_above_0v4 <= i_fb_good && (i_soft_start_ramp != 8'h00);
    end
    assign o_osc_cycle = osc_reg[1];
endmodule : bsh_stage_model
`default_nettype wire

// >>> dv/bsh_ctrl_tb_top.sv
// self-checking bench for the soft-start and hiccup sequencer
`timescale 1ns/100ps
`default_nettype none
module bsh_ctrl_tb_top;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic bias_ok = 1'b0;
    logic en_ok = 1'b0;
    logic [1:0] fb_code = 2'h0;
    logic comp_det = 1'b0;
    logic overload = 1'b0;
    logic fb_good = 1'b0;
    logic [3:0] pwm_len = 4'h8;
    logic osc, pwm_end, trip, fb_hi, ho, lo, clamp, skip, hiccup, comp_int;
    logic [7:0] ramp;
    bsh_pkg::bsh_setpoint_type setp;
    int mismatches = 0;
    int num_checks = 0;
    int ticks = 0;
    logic [3:0] trip_hist = 4'h0;

    bsh_ctrl #(.RAMP_W(8), .SS_CYCLES(2560)) DUT (.i_ref_clk(clk), .i_rst(rst),
        .i_analog_bias_rail_ok(bias_ok), .i_enable_ok(en_ok), .i_feedback_sense_code(fb_code),
        .i_compensation_node_det(comp_det), .i_osc_cycle(osc), .i_pwm_end(pwm_end),
        .i_current_sense_pos_trip(trip), .i_feedback_sense_above_0v4(fb_hi),
        .o_high_side_gate_drive(ho), .o_low_side_gate_drive(lo), .o_soft_start_ramp(ramp),
        .o_ss_clamp_en(clamp), .o_pulse_skip(skip), .o_hiccup(hiccup),
        .o_setpoint_sel(setp), .o_comp_internal(comp_int));
    bsh_stage_model stage (.i_ref_clk(clk), .i_high_side_gate_drive(ho), .i_soft_start_ramp(ramp),
        .i_overload(overload), .i_fb_good(fb_good), .i_pwm_len(pwm_len), .o_osc_cycle(osc),
        .o_pwm_end(pwm_end), .o_current_sense_pos_trip(trip), .o_feedback_sense_above_0v4(fb_hi));

    initial
    begin
        forever #20 clk = ~clk;
    end
    always @(posedge osc) ticks++;

    task automatic chk(input logic ok, input string msg);
        num_checks++;
        if (ok !== 1'b1)
        begin
            mismatches++;
            $display("[FAIL] %0t %s", $time, msg);
        end
    endtask : chk

    // a high-side pulse must not outlive a standing trip; drives stay off in hiccup
    always @(negedge clk)
    begin
        trip_hist <= {trip_hist[2:0], trip === 1'b1};
        if (!rst && trip === 1'b1 && trip_hist[2:0] == 3'h7)
            chk(ho === 1'b0, "high side not cut within three cycles of a trip");
        if (!rst && trip_hist == 4'hf && ho === 1'b1)
            chk(1'b0, "high side still on under trip");
        if (!rst && hiccup === 1'b1 && (ho !== 1'b0 || lo !== 1'b0))
            chk(1'b0, "drive active in hiccup");
    end

    task automatic t_config();
        for (int i = 0; i < 4; i++)
        begin
            @(posedge clk) bias_ok <= 1'b0;
            repeat (6) @(posedge clk);
            fb_code <= i[1:0];
            comp_det <= i[0];
            @(posedge clk) bias_ok <= 1'b1;
            repeat (8) @(posedge clk);
            chk(setp === bsh_pkg::bsh_setpoint_type'(i[1:0]), "setpoint decode");
            chk(comp_int === i[0], "compensation decode");
            fb_code <= ~i[1:0];
            comp_det <= ~i[0];
            repeat (8) @(posedge clk);
            chk(setp === bsh_pkg::bsh_setpoint_type'(i[1:0]), "setpoint not latched");
            chk(comp_int === i[0], "compensation not latched");
        end
    endtask : t_config

    task automatic t_start();
        int n;
        int hi_seen;
        hi_seen = 0;
        repeat (60) @(posedge clk) hi_seen |= (ho === 1'b1);
        chk(hi_seen == 0 && ramp === 8'h00, "started without enable");
        en_ok <= 1'b1;
        overload <= 1'b1;
        n = 0;
        while (ramp !== 8'h01 && n < 80) @(posedge clk) n++;
        chk(n < 80, "soft start did not begin");
        n = 0;
        while (ramp !== 8'hff && n < 3000)
        begin
            @(posedge clk) n++;
            if (hiccup === 1'b1)
                n = 5000;
        end
        overload <= 1'b0;
        fb_good <= 1'b1;
        chk(n >= 2538 && n <= 2542, "soft start ramp length or early hiccup");
    endtask : t_start

    task automatic t_skip();
        int s;
        int l;
        s = 0;
        l = 0;
        @(posedge clk) pwm_len <= 4'h0;
        repeat (40)
        begin
            @(posedge clk);
            s |= (skip === 1'b1);
            l |= (lo === 1'b1);
        end
        chk(s == 1, "no pulse skipping below minimum on time");
        chk(l == 1, "low side never on across a skipped pulse");
        pwm_len <= 4'h8;
        repeat (40) @(posedge clk);
        chk(skip === 1'b0, "skipping at normal duty");
    endtask : t_skip

    task automatic t_hiccup();
        int t0;
        int n;
        @(posedge clk) overload <= 1'b1;
        t0 = ticks;
        while (ticks - t0 < 300) @(posedge clk);
        chk(hiccup === 1'b0, "hiccup too early");
        overload <= 1'b0;
        t0 = ticks;
        while (ticks - t0 < 6) @(posedge clk);
        overload <= 1'b1;
        t0 = ticks;
        while (hiccup !== 1'b1 && ticks - t0 < 600) @(posedge clk);
        chk(ticks - t0 >= 510 && ticks - t0 <= 515, "overload count");
        repeat (2) @(posedge clk);
        chk(ho === 1'b0 && lo === 1'b0 && ramp === 8'h00, "hiccup entry");
        overload <= 1'b0;
        n = 0;
        while (hiccup !== 1'b0 && n < 66000) @(posedge clk) n++;
        chk(n >= 65520 && n <= 65548, "off time length");
        chk(ramp <= 8'h01 && clamp === 1'b0, "restart not from zero");
        n = 0;
        while (ramp !== 8'hff && n < 2700) @(posedge clk) n++;
        chk(n < 2700, "restart ramp");
        overload <= 1'b1;
        t0 = ticks;
        while (clamp !== 1'b1 && ticks - t0 < 40) @(posedge clk);
        chk(ticks - t0 >= 15 && ticks - t0 <= 19, "clamp after sixteen events");
        overload <= 1'b0;
    endtask : t_hiccup

    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", num_checks, mismatches);
        if (mismatches == 0 && num_checks > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask : tally_and_finish

    initial
    begin
        repeat (4) @(posedge clk);
        rst <= 1'b0;
        t_config();
        t_start();
        t_skip();
        t_hiccup();
        tally_and_finish();
    end

    initial
    begin
        repeat (90000) @(posedge clk);
        mismatches++;
        tally_and_finish();
    end
endmodule : bsh_ctrl_tb_top
`default_nettype wire
